// ==== nbp_pkg.sv ====
// nbp_pkg: constants shared by the nibble port bank files
// assumes a 12-bit data address with the port bank in the top page
package nbp_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int NIB_W = 4;
    localparam int PIN_W = 36;
    // page selects within bank 15
    localparam logic [7:0] PAGE_PORT = 8'hFF;
    localparam logic [7:0] PAGE_CTRL = 8'hFE;
    // port latch addresses
    localparam logic [3:0] IDX_P0 = 4'h0;
    localparam logic [3:0] IDX_P1 = 4'h1;
    localparam logic [3:0] IDX_P2 = 4'h2;
    localparam logic [3:0] IDX_P3 = 4'h3;
    localparam logic [3:0] IDX_P4 = 4'h4;
    localparam logic [3:0] IDX_P5 = 4'h5;
    localparam logic [3:0] IDX_P6 = 4'h6;
    localparam logic [3:0] IDX_P7 = 4'h7;
    localparam logic [3:0] IDX_P8 = 4'h8;
    localparam logic [3:0] IDX_LAST = 4'hC;
    // control registers in the control page
    localparam logic [3:0] IDX_DIR0 = 4'h0;
    localparam logic [3:0] IDX_DIR2 = 4'h1;
    localparam logic [3:0] IDX_DIR3 = 4'h2;
    localparam logic [3:0] IDX_DIR6 = 4'h3;
    localparam logic [3:0] IDX_DIR7 = 4'h4;
    localparam logic [3:0] IDX_DIR8 = 4'h5;
    localparam logic [3:0] IDX_PULL_A = 4'h8;
    localparam logic [3:0] IDX_PULL_B = 4'h9;
    localparam logic [3:0] IDX_EDGE = 4'hA;
    localparam logic [3:0] IDX_ALT0 = 4'hB;
    localparam logic [3:0] IDX_ALT2 = 4'hC;
    // field positions
    localparam int PULL_A_P0 = 0;
    localparam int PULL_A_P1 = 1;
    localparam int PULL_A_P2 = 2;
    localparam int PULL_A_P3 = 3;
    localparam int PULL_B_P6 = 0;
    localparam int PULL_B_P8 = 1;
    localparam int EDGE_A_FALL = 0;
    localparam int EDGE_B_FALL = 1;
    // reset values
    localparam logic [3:0] RST_LATCH = 4'h0;
    localparam logic [3:0] RST_LATCH_OD = 4'hF;
    localparam logic [3:0] RST_DIR = 4'h0;
    localparam logic [3:0] RST_CTRL = 4'h0;
    localparam logic [3:0] NIB_ZERO = 4'h0;
endpackage

// ==== nbp_pin_sync.sv ====
// nbp_pin_sync: three-stage pin synchroniser with agreement filter and edge pulses
// assumes pins are asynchronous to i_mclk
`timescale 1ns/10ps
`default_nettype none
module nbp_pin_sync #(
    parameter int W = 1
) (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic [W-1:0] i_pin,
    output var logic [W-1:0] o_level,
    output var logic [W-1:0] o_rise,
    output var logic [W-1:0] o_fall
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] level_next;
    // a change counts only once stages two and three agree
    assign level_next = (s2_reg & s3_reg) | (o_level & (s2_reg ^ s3_reg));
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            o_level <= '0;
            o_rise <= '0;
            o_fall <= '0;
        end else begin
            s1_reg <= i_pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            o_level <= level_next;
            o_rise <= level_next & ~o_level;
            o_fall <= ~level_next & o_level;
        end
    end
endmodule
`default_nettype wire

// ==== nbp_bank.sv ====
// nbp_bank: nine nibble-wide ports mapped into the top data page
// assumes a single-cycle strobe bus master on i_mclk and external pad logic
// Function
// - port latches at FF0H..FFCH, bank 15
// - 36 pins: 4 in, 24 io, 8 open-drain
// - latches readable, writable, testable per bit
// - port 0 per-pin direction, bit/nibble access
// - port 0 group pull-up, off on outputs
// - port 1 input only, pull-ups low three
// - ports 4/5 open-drain, pairable to byte
// - ports 4/5 pull-ups by mask option
// - ports 4/5 released high after reset
// - port 6 direction and pull-up, port 7 direction only
// - ports 6/7 bit, nibble and byte access
// - port 8 direction, group pull-down, off outputs
// - two interrupt pins with selectable edge, synchronised
// - quasi interrupt pin flags rising edges
// - fourth port 1 pin flags both edges
// - key scan pins flag falling edges
`timescale 1ns/10ps
`default_nettype none
module nbp_bank #(
    parameter logic PULLUP45_OPT = 1'b1
) (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic [nbp_pkg::ADDR_W-1:0] i_addr,
    input wire logic [nbp_pkg::DATA_W-1:0] i_wdata,
    input wire logic [nbp_pkg::DATA_W-1:0] i_wmask,
    input wire logic i_wide,
    input wire logic i_wr,
    input wire logic i_rd,
    output var logic [nbp_pkg::DATA_W-1:0] o_rdata,
    input wire logic [3:0] i_p0_in,
    output logic [3:0] o_p0_out,
    output logic [3:0] o_p0_oe_n,
    output logic [3:0] o_p0_pu,
    input wire logic [3:0] i_p1_in,
    output logic [2:0] o_p1_pu,
    input wire logic [3:0] i_p2_in,
    output logic [3:0] o_p2_out,
    output logic [3:0] o_p2_oe_n,
    output logic [3:0] o_p2_pu,
    input wire logic [3:0] i_p3_in,
    output logic [3:0] o_p3_out,
    output logic [3:0] o_p3_oe_n,
    output logic [3:0] o_p3_pu,
    input wire logic [3:0] i_p4_in,
    output logic [3:0] o_p4_out,
    output logic [3:0] o_p4_oe_n,
    input wire logic [3:0] i_p5_in,
    output logic [3:0] o_p5_out,
    output logic [3:0] o_p5_oe_n,
    output logic [7:0] o_p45_pu,
    input wire logic [3:0] i_p6_in,
    output logic [3:0] o_p6_out,
    output logic [3:0] o_p6_oe_n,
    output logic [3:0] o_p6_pu,
    input wire logic [3:0] i_p7_in,
    output logic [3:0] o_p7_out,
    output logic [3:0] o_p7_oe_n,
    input wire logic [3:0] i_p8_in,
    output logic [3:0] o_p8_out,
    output logic [3:0] o_p8_oe_n,
    output logic [3:0] o_p8_pd,
    input wire logic i_serial_clk_out,
    input wire logic i_serial_data_out,
    input wire logic i_basic_timer_out,
    input wire logic i_timer_a_out,
    input wire logic i_timer_b_out,
    input wire logic i_clock_out_pin,
    input wire logic i_buzzer_out,
    output logic o_serial_data_in,
    output logic o_timer_a_ext_clk,
    output logic o_timer_b_ext_clk,
    output var logic o_ext_irq_a_in,
    output var logic o_ext_irq_b_in,
    output var logic o_quasi_irq_rise_in,
    output var logic o_ext_irq_both_edge_in,
    output var logic [7:0] o_key_scan_in
);
    import nbp_pkg::*;

    function automatic logic [3:0] merge(input logic [3:0] old, input logic [3:0] data,
                                         input logic [3:0] mask);
        merge = (old & ~mask) | (data & mask);
    endfunction

    // port latches; port 1 is input only and keeps none
    logic [3:0] lat0_reg;
    logic [3:0] lat2_reg;
    logic [3:0] lat3_reg;
    logic [3:0] lat4_reg;
    logic [3:0] lat5_reg;
    logic [3:0] lat6_reg;
    logic [3:0] lat7_reg;
    logic [3:0] lat8_reg;

    // direction nibbles, a one makes the pin an output
    logic [3:0] dir0_reg;
    logic [3:0] dir2_reg;
    logic [3:0] dir3_reg;
    logic [3:0] dir6_reg;
    logic [3:0] dir7_reg;
    logic [3:0] dir8_reg;

    // pull, edge and alternate-function controls
    logic [3:0] pull_a_reg;
    logic [3:0] pull_b_reg;
    logic [3:0] edge_reg;
    logic [3:0] alt0_reg;
    logic [3:0] alt2_reg;

    logic [PIN_W-1:0] pins_raw;
    logic [PIN_W-1:0] pin_lvl;
    logic [PIN_W-1:0] pin_rise;
    logic [PIN_W-1:0] pin_fall;

    // all pins pass the same synchroniser, so interrupt inputs are clocked too
    assign pins_raw = {i_p8_in, i_p7_in, i_p6_in, i_p5_in, i_p4_in,
                       i_p3_in, i_p2_in, i_p1_in, i_p0_in};

    nbp_pin_sync #(
        .W(PIN_W)
    ) u_sync (
        .i_mclk(i_mclk),
        .i_rstn(i_rstn),
        .i_pin(pins_raw),
        .o_level(pin_lvl),
        .o_rise(pin_rise),
        .o_fall(pin_fall)
    );

    wire [3:0] pv0 = pin_lvl[3:0];
    wire [3:0] pv1 = pin_lvl[7:4];
    wire [3:0] pv2 = pin_lvl[11:8];
    wire [3:0] pv3 = pin_lvl[15:12];
    wire [3:0] pv4 = pin_lvl[19:16];
    wire [3:0] pv5 = pin_lvl[23:20];
    wire [3:0] pv6 = pin_lvl[27:24];
    wire [3:0] pv7 = pin_lvl[31:28];
    wire [3:0] pv8 = pin_lvl[35:32];

    // address decode
    wire [3:0] idx = i_addr[3:0];
    wire port_page = (i_addr[11:4] == PAGE_PORT) && (idx <= IDX_LAST);
    wire ctrl_page = i_addr[11:4] == PAGE_CTRL;
    // byte access only at the even address of a pairable port pair
    wire pair_ok = i_wide && ((idx == IDX_P4) || (idx == IDX_P6));
    wire [3:0] hi_idx = {idx[3:1], 1'b1};
    wire pwr = i_wr && port_page;
    wire cwr = i_wr && ctrl_page;
    wire [3:0] mlo = i_wmask[3:0];
    wire [3:0] mhi = i_wmask[7:4];
    wire [3:0] dlo = i_wdata[3:0];
    wire [3:0] dhi = i_wdata[7:4];

    wire we_p0 = pwr && (idx == IDX_P0);
    wire we_p2 = pwr && (idx == IDX_P2);
    wire we_p3 = pwr && (idx == IDX_P3);
    wire we_p4 = pwr && (idx == IDX_P4);
    wire we_p5 = pwr && (idx == IDX_P5);
    // a byte write reaches the odd partner through its high nibble
    wire we_p5h = pwr && pair_ok && (idx == IDX_P4);
    wire we_p6 = pwr && (idx == IDX_P6);
    wire we_p7 = pwr && (idx == IDX_P7);
    wire we_p7h = pwr && pair_ok && (idx == IDX_P6);
    wire we_p8 = pwr && (idx == IDX_P8);

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            lat0_reg <= RST_LATCH;
            lat2_reg <= RST_LATCH;
            lat3_reg <= RST_LATCH;
            lat4_reg <= RST_LATCH_OD;
            lat5_reg <= RST_LATCH_OD;
            lat6_reg <= RST_LATCH;
            lat7_reg <= RST_LATCH;
            lat8_reg <= RST_LATCH;
        end else begin
            if (we_p0) lat0_reg <= merge(lat0_reg, dlo, mlo);
            if (we_p2) lat2_reg <= merge(lat2_reg, dlo, mlo);
            if (we_p3) lat3_reg <= merge(lat3_reg, dlo, mlo);
            if (we_p4) lat4_reg <= merge(lat4_reg, dlo, mlo);
            if (we_p5) lat5_reg <= merge(lat5_reg, dlo, mlo);
            else if (we_p5h) lat5_reg <= merge(lat5_reg, dhi, mhi);
            if (we_p6) lat6_reg <= merge(lat6_reg, dlo, mlo);
            if (we_p7) lat7_reg <= merge(lat7_reg, dlo, mlo);
            else if (we_p7h) lat7_reg <= merge(lat7_reg, dhi, mhi);
            if (we_p8) lat8_reg <= merge(lat8_reg, dlo, mlo);
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            dir0_reg <= RST_DIR;
            dir2_reg <= RST_DIR;
            dir3_reg <= RST_DIR;
            dir6_reg <= RST_DIR;
            dir7_reg <= RST_DIR;
            dir8_reg <= RST_DIR;
            pull_a_reg <= RST_CTRL;
            pull_b_reg <= RST_CTRL;
            edge_reg <= RST_CTRL;
            alt0_reg <= RST_CTRL;
            alt2_reg <= RST_CTRL;
        end else if (cwr) begin
            case (idx)
                IDX_DIR0: dir0_reg <= merge(dir0_reg, dlo, mlo);
                IDX_DIR2: dir2_reg <= merge(dir2_reg, dlo, mlo);
                IDX_DIR3: dir3_reg <= merge(dir3_reg, dlo, mlo);
                IDX_DIR6: dir6_reg <= merge(dir6_reg, dlo, mlo);
                IDX_DIR7: dir7_reg <= merge(dir7_reg, dlo, mlo);
                IDX_DIR8: dir8_reg <= merge(dir8_reg, dlo, mlo);
                IDX_PULL_A: pull_a_reg <= merge(pull_a_reg, dlo, mlo);
                IDX_PULL_B: pull_b_reg <= merge(pull_b_reg, dlo, mlo);
                IDX_EDGE: edge_reg <= merge(edge_reg, dlo, mlo);
                IDX_ALT0: alt0_reg <= merge(alt0_reg, dlo, mlo);
                IDX_ALT2: alt2_reg <= merge(alt2_reg, dlo, mlo);
                // unused offsets keep no state and read as zero
                default: ;
            endcase
        end
    end

    // read view: output bits show the latch, input bits the synchronised pin
    wire [3:0] rv0 = (dir0_reg & lat0_reg) | (~dir0_reg & pv0);
    wire [3:0] rv2 = (dir2_reg & lat2_reg) | (~dir2_reg & pv2);
    wire [3:0] rv3 = (dir3_reg & lat3_reg) | (~dir3_reg & pv3);
    wire [3:0] rv6 = (dir6_reg & lat6_reg) | (~dir6_reg & pv6);
    wire [3:0] rv7 = (dir7_reg & lat7_reg) | (~dir7_reg & pv7);
    wire [3:0] rv8 = (dir8_reg & lat8_reg) | (~dir8_reg & pv8);

    // unmapped nibbles of both pages read as zero
    logic [3:0] port_tab [0:15];
    logic [3:0] ctrl_tab [0:15];
    assign port_tab[0] = rv0;
    assign port_tab[1] = pv1;
    assign port_tab[2] = rv2;
    assign port_tab[3] = rv3;
    assign port_tab[4] = pv4;
    assign port_tab[5] = pv5;
    assign port_tab[6] = rv6;
    assign port_tab[7] = rv7;
    assign port_tab[8] = rv8;
    assign port_tab[9] = NIB_ZERO;
    assign port_tab[10] = NIB_ZERO;
    assign port_tab[11] = NIB_ZERO;
    assign port_tab[12] = NIB_ZERO;
    assign port_tab[13] = NIB_ZERO;
    assign port_tab[14] = NIB_ZERO;
    assign port_tab[15] = NIB_ZERO;
    assign ctrl_tab[0] = dir0_reg;
    assign ctrl_tab[1] = dir2_reg;
    assign ctrl_tab[2] = dir3_reg;
    assign ctrl_tab[3] = dir6_reg;
    assign ctrl_tab[4] = dir7_reg;
    assign ctrl_tab[5] = dir8_reg;
    assign ctrl_tab[6] = NIB_ZERO;
    assign ctrl_tab[7] = NIB_ZERO;
    assign ctrl_tab[8] = pull_a_reg;
    assign ctrl_tab[9] = pull_b_reg;
    assign ctrl_tab[10] = edge_reg;
    assign ctrl_tab[11] = alt0_reg;
    assign ctrl_tab[12] = alt2_reg;
    assign ctrl_tab[13] = NIB_ZERO;
    assign ctrl_tab[14] = NIB_ZERO;
    assign ctrl_tab[15] = NIB_ZERO;

    // a byte read carries the odd partner port in the high nibble
    wire [3:0] rd_lo = port_page ? port_tab[idx] : (ctrl_page ? ctrl_tab[idx] : NIB_ZERO);
    wire [3:0] rd_hi = (port_page && pair_ok) ? port_tab[hi_idx] : NIB_ZERO;
    wire [7:0] rdata_next = i_rd ? {rd_hi, rd_lo} : 8'h00;

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rdata <= 8'h00;
        end else begin
            o_rdata <= rdata_next;
        end
    end

    // alternate output sources select per pin over the latch
    wire [3:0] alt0_src = {i_basic_timer_out, lat0_reg[2], i_serial_data_out, i_serial_clk_out};
    wire [3:0] alt2_src = {i_buzzer_out, i_clock_out_pin, i_timer_b_out, i_timer_a_out};
    assign o_p0_out = (alt0_reg & alt0_src) | (~alt0_reg & lat0_reg);
    assign o_p2_out = (alt2_reg & alt2_src) | (~alt2_reg & lat2_reg);
    assign o_p3_out = lat3_reg;
    assign o_p6_out = lat6_reg;
    assign o_p7_out = lat7_reg;
    assign o_p8_out = lat8_reg;
    assign o_p0_oe_n = ~dir0_reg;
    assign o_p2_oe_n = ~dir2_reg;
    assign o_p3_oe_n = ~dir3_reg;
    assign o_p6_oe_n = ~dir6_reg;
    assign o_p7_oe_n = ~dir7_reg;
    assign o_p8_oe_n = ~dir8_reg;
    // open-drain: only a zero is driven, a one releases the pin
    assign o_p4_out = 4'h0;
    assign o_p5_out = 4'h0;
    assign o_p4_oe_n = lat4_reg;
    assign o_p5_oe_n = lat5_reg;
    // the pair pull-ups are fixed by the mask option, never by software
    assign o_p45_pu = {8{PULLUP45_OPT}};

    // group pulls, suppressed on output pins
    assign o_p0_pu = {4{pull_a_reg[PULL_A_P0]}} & ~dir0_reg;
    assign o_p1_pu = {3{pull_a_reg[PULL_A_P1]}};
    assign o_p2_pu = {4{pull_a_reg[PULL_A_P2]}} & ~dir2_reg;
    assign o_p3_pu = {4{pull_a_reg[PULL_A_P3]}} & ~dir3_reg;
    assign o_p6_pu = {4{pull_b_reg[PULL_B_P6]}} & ~dir6_reg;
    assign o_p8_pd = {4{pull_b_reg[PULL_B_P8]}} & ~dir8_reg;

    assign o_serial_data_in = pv0[2];
    assign o_timer_a_ext_clk = pv3[0];
    assign o_timer_b_ext_clk = pv3[1];

    // pin event selection, registered one cycle after the filtered edge
    wire ev_a = edge_reg[EDGE_A_FALL] ? pin_fall[4] : pin_rise[4];
    wire ev_b = edge_reg[EDGE_B_FALL] ? pin_fall[5] : pin_rise[5];
    wire ev_q = pin_rise[6];
    wire ev_both = pin_rise[7] | pin_fall[7];
    wire [7:0] ev_ks = pin_fall[31:24];

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_ext_irq_a_in <= 1'b0;
            o_ext_irq_b_in <= 1'b0;
            o_quasi_irq_rise_in <= 1'b0;
            o_ext_irq_both_edge_in <= 1'b0;
            o_key_scan_in <= 8'h00;
        end else begin
            o_ext_irq_a_in <= ev_a;
            o_ext_irq_b_in <= ev_b;
            o_quasi_irq_rise_in <= ev_q;
            o_ext_irq_both_edge_in <= ev_both;
            o_key_scan_in <= ev_ks;
        end
    end
endmodule
`default_nettype wire

// ==== nbp_bank_properties.sv ====
// nbp_bank_properties: boundary relations of the nibble port bank
// assumes one clock i_mclk and the asynchronous active-low reset i_rstn
`timescale 1ns/10ps
`default_nettype none
module nbp_bank_properties #(
    parameter logic PULLUP45_OPT = 1'b1
) (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic [nbp_pkg::ADDR_W-1:0] i_addr,
    input wire logic i_wide,
    input wire logic i_rd,
    input wire logic [nbp_pkg::DATA_W-1:0] o_rdata,
    input wire logic [3:0] i_p1_in,
    input wire logic [3:0] i_p6_in,
    input wire logic [3:0] o_p0_oe_n,
    input wire logic [3:0] o_p0_pu,
    input wire logic [3:0] o_p4_oe_n,
    input wire logic [3:0] o_p4_out,
    input wire logic [3:0] o_p5_out,
    input wire logic [7:0] o_p45_pu,
    input wire logic [3:0] o_p6_oe_n,
    input wire logic [3:0] o_p6_pu,
    input wire logic [3:0] o_p8_oe_n,
    input wire logic [3:0] o_p8_pd,
    input wire logic o_quasi_irq_rise_in,
    input wire logic [7:0] o_key_scan_in
);
    import nbp_pkg::*;
    default clocking dflt_cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rstn);
    sequence nib_read_s;
        i_rd && !i_wide && i_addr[11:4] == 8'hFF;
    endsequence
    sequence far_read_s;
        i_rd && i_addr[11:8] != 4'hF;
    endsequence
    rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data present without a read");
    nib_upper_a: assert property (nib_read_s |=> o_rdata[7:4] == 4'h0)
        else $error("nibble read sets upper bits");
    far_read_a: assert property (far_read_s |=> o_rdata == 8'h00)
        else $error("read outside the port bank returns data");
    p0_pull_a: assert property ((o_p0_pu & ~o_p0_oe_n) == 4'h0)
        else $error("port 0 pull-up on a driven pin");
    p6_pull_a: assert property ((o_p6_pu & ~o_p6_oe_n) == 4'h0)
        else $error("port 6 pull-up on a driven pin");
    p8_pull_a: assert property ((o_p8_pd & ~o_p8_oe_n) == 4'h0)
        else $error("port 8 pull-down on a driven pin");
    od_pins_a: assert property ((o_p4_out | o_p5_out) == 4'h0 &&
        o_p45_pu == {8{PULLUP45_OPT}})
        else $error("open-drain pair drives high or pull-ups move");
    reset_dir_a: assert property (!$past(i_rstn) |->
        {o_p0_oe_n, o_p6_oe_n, o_p8_oe_n, o_p4_oe_n} == 16'hFFFF)
        else $error("pins not released after reset");
    quasi_edge_a: assert property (o_quasi_irq_rise_in |->
        $past(i_p1_in[2], 2) ##1 !o_quasi_irq_rise_in)
        else $error("quasi event without a rising pin or too long");
    key_edge_a: assert property (o_key_scan_in[0] |->
        !$past(i_p6_in[0], 2) ##1 !o_key_scan_in[0])
        else $error("key event without a falling pin or too long");
endmodule
bind nbp_bank nbp_bank_properties #(.PULLUP45_OPT(PULLUP45_OPT)) nbp_bank_props (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wide(i_wide), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_p1_in(i_p1_in), .i_p6_in(i_p6_in), .o_p0_oe_n(o_p0_oe_n),
    .o_p0_pu(o_p0_pu), .o_p4_oe_n(o_p4_oe_n), .o_p4_out(o_p4_out), .o_p5_out(o_p5_out),
    .o_p45_pu(o_p45_pu), .o_p6_oe_n(o_p6_oe_n), .o_p6_pu(o_p6_pu), .o_p8_oe_n(o_p8_oe_n),
    .o_p8_pd(o_p8_pd), .o_quasi_irq_rise_in(o_quasi_irq_rise_in), .o_key_scan_in(o_key_scan_in));
`default_nettype wire

// ==== nbp_pin_model.sv ====
// nbp_pin_model: board level seen on every port pin
// assumes enable low means the bank drives; a pin left with no pull wanders
`timescale 1ns/10ps
`default_nettype none
module nbp_pin_model #(
    parameter int W = 36
) (
    input wire logic i_mclk,
    input wire logic [W-1:0] i_out,
    input wire logic [W-1:0] i_oe_n,
    input wire logic [W-1:0] i_pu,
    input wire logic [W-1:0] i_pd,
    input wire logic [W-1:0] i_ext,
    input wire logic [W-1:0] i_ext_en,
    output var logic [W-1:0] o_pin
);
    logic [W-1:0] last_reg;
    always_ff @(posedge i_mclk) begin
        last_reg <= o_pin;
    end
    always_comb begin
        for (int b = 0; b < W; b++) begin
            if (!i_oe_n[b]) begin
                o_pin[b] = i_out[b];
            end else if (i_ext_en[b]) begin
                o_pin[b] = i_ext[b];
            end else if (i_pu[b]) begin
                o_pin[b] = 1'b1;
            end else if (i_pd[b]) begin
                o_pin[b] = 1'b0;
            end else begin
                o_pin[b] = ~last_reg[b];
            end
        end
    end
endmodule
`default_nettype wire

// ==== nbp_bank_tb_top.sv ====
// nbp_bank_tb_top: register and pin scenarios for the nibble port bank
// assumes the pin model closes every pad; strobes are one cycle apart
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin n_fail++; \
    $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module nbp_bank_tb_top;
    import nbp_pkg::*;
    logic i_mclk, i_rstn, i_wide, i_wr, i_rd;
    logic [ADDR_W-1:0] i_addr;
    logic [DATA_W-1:0] i_wdata, i_wmask;
    logic [6:0] alt_src;
    logic [35:0] ext, ext_en;
    wire logic [35:0] pin;
    wire logic [DATA_W-1:0] o_rdata;
    wire logic [3:0] p0o, p0e, p0u, p2o, p2e, p2u, p3o, p3e, p3u, p4o, p4e, p5o, p5e;
    wire logic [3:0] p6o, p6e, p6u, p7o, p7e, p8o, p8e, p8d;
    wire logic [2:0] p1u;
    wire logic [7:0] p45u, ks;
    wire logic sdi, tca, tcb, irq_a, irq_b, irq_q, irq_4;
    int n_fail = 0, checked = 0;
    integer n_a = 0, n_b = 0, n_q = 0, n_4 = 0, n_k = 0;
    nbp_bank #(.PULLUP45_OPT(1'b1)) nbp_bank_i (.i_mclk(i_mclk), .i_rstn(i_rstn),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wmask(i_wmask), .i_wide(i_wide), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .i_p0_in(pin[3:0]), .o_p0_out(p0o), .o_p0_oe_n(p0e),
        .o_p0_pu(p0u), .i_p1_in(pin[7:4]), .o_p1_pu(p1u), .i_p2_in(pin[11:8]), .o_p2_out(p2o),
        .o_p2_oe_n(p2e), .o_p2_pu(p2u), .i_p3_in(pin[15:12]), .o_p3_out(p3o), .o_p3_oe_n(p3e),
        .o_p3_pu(p3u), .i_p4_in(pin[19:16]), .o_p4_out(p4o), .o_p4_oe_n(p4e),
        .i_p5_in(pin[23:20]), .o_p5_out(p5o), .o_p5_oe_n(p5e), .o_p45_pu(p45u),
        .i_p6_in(pin[27:24]), .o_p6_out(p6o), .o_p6_oe_n(p6e), .o_p6_pu(p6u),
        .i_p7_in(pin[31:28]), .o_p7_out(p7o), .o_p7_oe_n(p7e), .i_p8_in(pin[35:32]),
        .o_p8_out(p8o), .o_p8_oe_n(p8e), .o_p8_pd(p8d), .i_serial_clk_out(alt_src[0]),
        .i_serial_data_out(alt_src[1]), .i_basic_timer_out(alt_src[2]),
        .i_timer_a_out(alt_src[3]), .i_timer_b_out(alt_src[4]), .i_clock_out_pin(alt_src[5]),
        .i_buzzer_out(alt_src[6]), .o_serial_data_in(sdi), .o_timer_a_ext_clk(tca),
        .o_timer_b_ext_clk(tcb), .o_ext_irq_a_in(irq_a), .o_ext_irq_b_in(irq_b),
        .o_quasi_irq_rise_in(irq_q), .o_ext_irq_both_edge_in(irq_4), .o_key_scan_in(ks));
    nbp_pin_model #(.W(36)) pins_m (.i_mclk(i_mclk),
        .i_out({p8o, p7o, p6o, p5o, p4o, p3o, p2o, 4'h0, p0o}),
        .i_oe_n({p8e, p7e, p6e, p5e, p4e, p3e, p2e, 4'hF, p0e}),
        .i_pu({8'h00, p6u, p45u, p3u, p2u, 1'b0, p1u, p0u}),
        .i_pd({p8d, 32'h0}), .i_ext(ext), .i_ext_en(ext_en), .o_pin(pin));
    always @(posedge i_mclk) begin
        n_a <= n_a + (irq_a ? 1 : 0);
        n_b <= n_b + (irq_b ? 1 : 0);
        n_q <= n_q + (irq_q ? 1 : 0);
        n_4 <= n_4 + (irq_4 ? 1 : 0);
        n_k <= $isunknown(ks) ? 'x : n_k + $countones(ks);
    end
    task automatic idle(input int n);
        repeat (n) @(posedge i_mclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [7:0] m,
            input logic w);
        @(posedge i_mclk);
        i_addr <= a;
        i_wdata <= d;
        i_wmask <= m;
        i_wide <= w;
        i_wr <= 1'b1;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic w, input logic [7:0] ex);
        @(posedge i_mclk);
        i_addr <= a;
        i_wide <= w;
        i_rd <= 1'b1;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        @(negedge i_mclk);
        `CHK("o_rdata", ex, o_rdata)
    endtask
    task automatic toggle(input int k);
        @(posedge i_mclk);
        ext[k] <= 1'b1;
        idle(10);
        ext[k] <= 1'b0;
        idle(10);
    endtask
    task automatic complete_run();
        $display("checks %0d failures %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end
    initial begin
        #50us;
        n_fail++;
        complete_run();
    end
    initial begin
        {i_rstn, i_wide, i_wr, i_rd, i_addr, i_wdata, i_wmask, alt_src} = '0;
        ext = '0;
        ext_en = 36'hFFF00FFFF;
        repeat (20) @(posedge i_mclk);
        i_rstn <= 1'b1;
        @(negedge i_mclk);
        `CHK("p0/p8 oe_n", 8'hFF, {p0e, p8e})
        `CHK("p4/p5 pins", 8'hFF, pin[23:16])
        `CHK("o_p45_pu", 8'hFF, p45u)
        $display("test reset done");
        toggle(4);
        wr(12'hFEA, 8'h01, 8'h0F, 1'b0);
        toggle(4);
        toggle(5);
        toggle(6);
        toggle(7);
        for (int k = 24; k < 32; k++) toggle(k);
        `CHK("irq a, b", 64'h2_0000_0001, {n_a, n_b})
        `CHK("quasi", 1, n_q)
        `CHK("both edge", 2, n_4)
        `CHK("key scan", 8, n_k)
        $display("test events done");
        ext[3:0] <= 4'hA;
        wr(12'hFE0, 8'h03, 8'h0F, 1'b0);
        wr(12'hFF0, 8'h05, 8'h0F, 1'b0);
        wr(12'hFF0, 8'h02, 8'h02, 1'b0);
        wr(12'hFE8, 8'h0F, 8'h0F, 1'b0);
        wr(12'hFE1, 8'h09, 8'h0F, 1'b0);
        wr(12'hFE2, 8'h06, 8'h0F, 1'b0);
        wr(12'hFE3, 8'h03, 8'h0F, 1'b0);
        wr(12'hFE5, 8'h01, 8'h0F, 1'b0);
        wr(12'hFE9, 8'h03, 8'h0F, 1'b0);
        idle(8);
        rd(12'hFF0, 1'b0, 8'h0B);
        `CHK("p0 out, oe_n", 8'h7C, {p0o, p0e})
        `CHK("p0 pu, p1 pu", 7'h67, {p0u, p1u})
        `CHK("p2/p3 oe_n, pu", 16'h6699, {p2e, p2u, p3e, p3u})
        `CHK("p6 pu, p8 pd", 8'hCE, {p6u, p8d})
        $display("test direction done");
        wr(12'hFF1, 8'h0A, 8'h0F, 1'b0);
        ext[7:4] <= 4'h5;
        idle(8);
        rd(12'hFF1, 1'b0, 8'h05);
        rd(12'hFF9, 1'b0, 8'h00);
        rd(12'h100, 1'b0, 8'h00);
        wr(12'hFF4, 8'h3C, 8'hFF, 1'b1);
        idle(8);
        rd(12'hFF4, 1'b1, 8'h3C);
        wr(12'hFF5, 8'h00, 8'h01, 1'b0);
        @(negedge i_mclk);
        `CHK("p4/p5 oe_n", 8'h2C, {p5e, p4e})
        wr(12'hFE3, 8'h0F, 8'h0F, 1'b0);
        wr(12'hFE4, 8'h0F, 8'h0F, 1'b0);
        wr(12'hFF6, 8'hA5, 8'hFF, 1'b1);
        idle(8);
        rd(12'hFF6, 1'b1, 8'hA5);
        `CHK("p7/p6 out, p6 pu", 12'hA50, {p7o, p6o, p6u})
        $display("test access done");
        wr(12'hFE0, 8'h01, 8'h0F, 1'b0);
        wr(12'hFEB, 8'h01, 8'h0F, 1'b0);
        wr(12'hFEC, 8'h0F, 8'h0F, 1'b0);
        wr(12'hFF3, 8'h03, 8'h0F, 1'b0);
        wr(12'hFF8, 8'h06, 8'h0F, 1'b0);
        alt_src <= 7'h51;
        ext[3:0] <= 4'h4;
        ext[12] <= 1'b1;
        idle(8);
        @(negedge i_mclk);
        `CHK("alt out, sync in", 4'hF, {p0o[0], sdi, tca, tcb})
        `CHK("p2 alt, p3/p8 out", 12'hA36, {p2o, p3o, p8o})
        @(posedge i_mclk);
        alt_src <= 7'h00;
        @(negedge i_mclk);
        `CHK("alt out low", 5'h00, {p0o[0], p2o})
        $display("test alternate done");
        @(posedge i_mclk);
        i_rstn <= 1'b0;
        idle(3);
        i_rstn <= 1'b1;
        @(negedge i_mclk);
        `CHK("oe_n after reset", 16'hFFFF, {p0e, p6e, p7e, p4e})
        $display("test second reset done");
        complete_run();
    end
endmodule
`default_nettype wire
